// file: rtl/cms_status_summary.sv
// top of the message status summary: flag store, register read port,
// transmit candidate and interrupt source selection
// assumes: all event inputs come from logic on clk_in, one-cycle pulses,
// object numbers 1..32 (0 and above 32 address nothing)
`timescale 1ns/1ns
`default_nettype none
module cms_status_summary
  import cms_pkg::*;
(
  input wire logic clk_in, // controller clock
  input wire logic rst_n_in, // synchronous, active low
  // register port
  input wire logic reg_select_in, // register access strobe
  input wire logic reg_write_n_in, // high read, low write
  input wire logic [1:0] reg_size_in, // write size, unused here
  input wire logic [7:0] reg_addr_in, // byte address
  input wire logic [31:0] reg_wdata_in, // write data, unused here
  output logic [31:0] reg_rdata_out, // read data, zero when idle
  // message interface transfer command
  input wire logic xfer_valid_in, // transfer command issued
  input wire logic xfer_write_in, // 1 interface to object
  input wire logic [5:0] xfer_obj_in, // object number 1..32
  input wire logic sel_tx_request_in,
  input wire logic sel_control_in,
  input wire logic sel_arb_in,
  input wire logic sel_fresh_data_in,
  input wire logic clear_pending_select_in,
  input wire logic ctl_tx_request_in, // message control values
  input wire logic ctl_fresh_data_in,
  input wire logic ctl_irq_pending_in,
  input wire logic arb_valid_in, // arbitration 2 valid value
  // bus engine events
  input wire logic tx_done_in, // frame sent successfully
  input wire logic [5:0] tx_obj_in,
  input wire logic tx_irq_enable_in,
  input wire logic rx_store_in, // accepted frame stored
  input wire logic [5:0] rx_obj_in,
  input wire logic rx_remote_in,
  input wire logic rx_dir_tx_in,
  input wire logic remote_reply_enable_in,
  input wire logic mask_use_enable_in,
  input wire logic rx_irq_enable_in,
  input wire logic shift_load_in, // object copied to shift register
  input wire logic [5:0] shift_obj_in,
  input wire logic bus_valid_msg_in, // any valid message seen on bus
  input wire logic init_in, // controller initialisation
  input wire logic higher_irq_in, // status interrupt outranks objects
  // status outputs
  output logic tx_candidate_valid_out,
  output logic [5:0] tx_candidate_obj_out,
  output logic [15:0] interrupt_source_id_out,
  output logic irq_pending_any_out
);

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] tx_request_flag; // bit n-1 holds object n
    logic [31:0] fresh_data_flag;
    logic [31:0] irq_pending_flag;
    logic [31:0] object_valid_flag;
    cms_hold_t hold; // lowest-object abort hazard
    logic [31:0] rdata;
    logic cand_valid;
    logic [5:0] cand_obj;
    logic [15:0] irq_id;
    logic irq_any;
  } cms_state_t;

  cms_state_t st_r; // registered state
  cms_state_t st_nxt; // next state

  // ---------------------------------------------------------------
  // object number to one-hot hit vector
  // ---------------------------------------------------------------
  function automatic logic [31:0] obj_hit(input logic [5:0] num, input logic en);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (en && num != 6'h00 && num <= CMS_LAST_OBJ) begin
      v[5'(num - 6'h01)] = 1'b1;
    end
    return v;
  endfunction : obj_hit

  // ---------------------------------------------------------------
  // lowest set bit as object number, zero when none
  // ---------------------------------------------------------------
  function automatic logic [5:0] lowest_obj(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = CMS_NUM_OBJ - 1; i >= 0; i--) begin
      if (v[i]) begin
        n = 6'(i + 1);
      end
    end
    return n;
  endfunction : lowest_obj

  logic [31:0] xfer_hit; // decoded event targets
  logic [31:0] tx_hit;
  logic [31:0] rx_hit;
  logic [31:0] shift_hit;
  logic [31:0] tx_req_new; // flag next values from the cells
  logic [31:0] fresh_new;
  logic [31:0] pend_new;
  logic [31:0] valid_new;

  assign xfer_hit = obj_hit(xfer_obj_in, xfer_valid_in);
  assign tx_hit = obj_hit(tx_obj_in, tx_done_in);
  assign rx_hit = obj_hit(rx_obj_in, rx_store_in);
  assign shift_hit = obj_hit(shift_obj_in, shift_load_in);

  // ---------------------------------------------------------------
  // one flag cell per message object
  // ---------------------------------------------------------------
  for (genvar g = 0; g < CMS_NUM_OBJ; g++) begin : g_obj
    cms_object_flags u_flags (
      .tx_req_in(st_r.tx_request_flag[g]),
      .fresh_in(st_r.fresh_data_flag[g]),
      .pend_in(st_r.irq_pending_flag[g]),
      .valid_in(st_r.object_valid_flag[g]),
      .xfer_hit_in(xfer_hit[g]),
      .xfer_write_in(xfer_write_in),
      .sel_tx_request_in(sel_tx_request_in),
      .sel_control_in(sel_control_in),
      .sel_arb_in(sel_arb_in),
      .sel_fresh_data_in(sel_fresh_data_in),
      .clear_pending_select_in(clear_pending_select_in),
      .ctl_tx_request_in(ctl_tx_request_in),
      .ctl_fresh_data_in(ctl_fresh_data_in),
      .ctl_irq_pending_in(ctl_irq_pending_in),
      .arb_valid_in(arb_valid_in),
      .tx_hit_in(tx_hit[g]),
      .tx_irq_enable_in(tx_irq_enable_in),
      .rx_hit_in(rx_hit[g]),
      .rx_remote_in(rx_remote_in),
      .rx_dir_tx_in(rx_dir_tx_in),
      .remote_reply_enable_in(remote_reply_enable_in),
      .mask_use_enable_in(mask_use_enable_in),
      .rx_irq_enable_in(rx_irq_enable_in),
      .shift_hit_in(shift_hit[g]),
      .tx_req_out(tx_req_new[g]),
      .fresh_out(fresh_new[g]),
      .pend_out(pend_new[g]),
      .valid_out(valid_new[g])
    );
  end

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic last_was;
    logic last_now;
    logic last_xfer;
    logic release_hold;
    logic other_set;
    logic [31:0] sendable;
    logic [31:0] rd_word;
    st_nxt = st_r;
    rd_word = CMS_RDATA_RST;
    // abort-hazard watcher on the lowest-priority object
    last_was = st_r.tx_request_flag[CMS_NUM_OBJ - 1];
    last_now = tx_req_new[CMS_NUM_OBJ - 1];
    last_xfer = xfer_hit[CMS_NUM_OBJ - 1] && xfer_write_in;
    // a request on any other object counts as a release
    other_set = |(tx_req_new[CMS_NUM_OBJ - 2:0] &
                  ~st_r.tx_request_flag[CMS_NUM_OBJ - 2:0]);
    release_hold = bus_valid_msg_in || other_set || init_in;
    sendable = tx_req_new & valid_new;

    // flags follow the cells every cycle
    st_nxt.tx_request_flag = tx_req_new;
    st_nxt.fresh_data_flag = fresh_new;
    st_nxt.irq_pending_flag = pend_new;
    st_nxt.object_valid_flag = valid_new;

    case (st_r.hold)
      CMS_HOLD_IDLE: begin
        // aborted by software while pending
        if (last_xfer && last_was && !last_now) begin
          st_nxt.hold = CMS_HOLD_ARMED;
        end
      end
      CMS_HOLD_ARMED: begin
        if (release_hold) begin
          st_nxt.hold = CMS_HOLD_IDLE;
        end else if (last_xfer && last_now) begin
          st_nxt.hold = CMS_HOLD_STUCK;
        end else if (!last_now && !last_xfer) begin
          st_nxt.hold = CMS_HOLD_ARMED;
        end
      end
      CMS_HOLD_STUCK: begin
        // withheld until a releasing event or the request goes away
        if (release_hold || !last_now) begin
          st_nxt.hold = CMS_HOLD_IDLE;
        end
      end
      default: begin
        st_nxt.hold = CMS_HOLD_IDLE;
      end
    endcase

    // transmit candidate: lowest number wins, invalid objects skipped
    if (st_nxt.hold == CMS_HOLD_STUCK) begin
      sendable[CMS_NUM_OBJ - 1] = 1'b0;
    end
    st_nxt.cand_valid = |sendable;
    st_nxt.cand_obj = lowest_obj(sendable);

    // interrupt source: a higher source outranks every object
    st_nxt.irq_any = |pend_new;
    if (higher_irq_in) begin
      st_nxt.irq_id = CMS_ID_STATUS;
    end else if (|pend_new) begin
      st_nxt.irq_id = {10'h000, lowest_obj(pend_new)};
    end else begin
      st_nxt.irq_id = CMS_ID_NONE;
    end

    // register read; address bits 7:2 pick the word, bit 1 the upper half, size ignored
    if (reg_select_in && reg_write_n_in) begin
      case ({reg_addr_in[7:2], 2'b00})
        CMS_TX_REQUEST_LOWER_OFS: begin
          rd_word = st_r.tx_request_flag;
        end
        CMS_FRESH_DATA_LOWER_OFS: begin
          rd_word = st_r.fresh_data_flag;
        end
        CMS_IRQ_PENDING_LOWER_OFS: begin
          rd_word = st_r.irq_pending_flag;
        end
        CMS_OBJECT_VALID_LOWER_OFS: begin
          rd_word = st_r.object_valid_flag;
        end
        default: begin
          rd_word = CMS_RDATA_RST; // unmapped reads as zero
        end
      endcase
      // a halfword read of the upper register lands in the low lanes
      if (reg_addr_in[1]) begin
        rd_word = {CMS_SUMMARY_RST, rd_word[31:16]};
      end
    end
    st_nxt.rdata = rd_word;
    // writes fall through here on purpose: nothing is stored
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r.tx_request_flag <= CMS_FLAGS_RST;
      st_r.fresh_data_flag <= CMS_FLAGS_RST;
      st_r.irq_pending_flag <= CMS_FLAGS_RST;
      st_r.object_valid_flag <= CMS_FLAGS_RST;
      st_r.hold <= CMS_HOLD_IDLE;
      st_r.rdata <= CMS_RDATA_RST;
      st_r.cand_valid <= 1'b0;
      st_r.cand_obj <= 6'h00;
      st_r.irq_id <= CMS_ID_NONE;
      st_r.irq_any <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from the state register
  // ---------------------------------------------------------------
  assign reg_rdata_out = st_r.rdata;
  assign tx_candidate_valid_out = st_r.cand_valid;
  assign tx_candidate_obj_out = st_r.cand_obj;
  assign interrupt_source_id_out = st_r.irq_id;
  assign irq_pending_any_out = st_r.irq_any;

endmodule : cms_status_summary
`default_nettype wire

// file: rtl/cms_pkg.sv
// package of constants for the message status summary block
// assumes: one 20 MHz controller clock, synchronous active-low reset
// Summary of operation
// - summary registers are read-only, writes ignored
// - two 16-bit registers per flag, reset zero
// - tx request 1 means sending or waiting
// - write transfer with request select sets request
// - control select loads tx request from control
// - transmit object with reply enabled: remote sets request
// - successful transmission clears tx request
// - reply off, mask on: remote clears request
// - lowest object abort-and-reset may withhold sending
// - fresh data 1 means valid unread data
// - accepted stored data frame sets fresh data
// - reply off, mask on: remote sets fresh data
// - read transfer with fresh select clears it
// - control select loads fresh data from control
// - shift register load clears fresh data
// - completed transfer with enable sets pending
// - read transfer with clear select clears pending
// - control select loads pending from control
// - invalid object takes no part in traffic
// - arbitration select loads valid flag
// - interrupt id reports lowest pending object
package cms_pkg;

  // -----------------------------------------------------------------
  // geometry
  // -----------------------------------------------------------------
  localparam int unsigned CMS_NUM_OBJ = 32; // message objects
  localparam int unsigned CMS_HALF_W = 16; // width of one summary register
  localparam logic [5:0] CMS_LAST_OBJ = 6'h20; // lowest-priority object number

  // -----------------------------------------------------------------
  // register byte offsets (16-bit registers, two per word)
  // -----------------------------------------------------------------
  localparam logic [7:0] CMS_TX_REQUEST_LOWER_OFS = 8'h80;
  localparam logic [7:0] CMS_TX_REQUEST_UPPER_OFS = 8'h82;
  localparam logic [7:0] CMS_FRESH_DATA_LOWER_OFS = 8'h90;
  localparam logic [7:0] CMS_FRESH_DATA_UPPER_OFS = 8'h92;
  localparam logic [7:0] CMS_IRQ_PENDING_LOWER_OFS = 8'hA0;
  localparam logic [7:0] CMS_IRQ_PENDING_UPPER_OFS = 8'hA2;
  localparam logic [7:0] CMS_OBJECT_VALID_LOWER_OFS = 8'hB0;
  localparam logic [7:0] CMS_OBJECT_VALID_UPPER_OFS = 8'hB2;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [15:0] CMS_SUMMARY_RST = 16'h0000;
  localparam logic [31:0] CMS_FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] CMS_RDATA_RST = 32'h0000_0000;
  localparam logic [15:0] CMS_ID_NONE = 16'h0000; // no pending source
  localparam logic [15:0] CMS_ID_STATUS = 16'h8000; // higher source reported

  // -----------------------------------------------------------------
  // state of the abort-hazard watcher on the lowest-priority object
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMS_HOLD_IDLE = 2'b00, // no hazard
    CMS_HOLD_ARMED = 2'b01, // request was aborted
    CMS_HOLD_STUCK = 2'b10 // request set again, sending withheld
  } cms_hold_t;

endpackage : cms_pkg

// file: rtl/cms_object_flags.sv
// next-state logic of the four status flags of one message object
// assumes: event hits are one-cycle pulses already decoded to this object
`timescale 1ns/1ns
`default_nettype none
module cms_object_flags (
  input wire logic tx_req_in, // current flags
  input wire logic fresh_in,
  input wire logic pend_in,
  input wire logic valid_in,
  input wire logic xfer_hit_in, // interface transfer addresses this object
  input wire logic xfer_write_in,
  input wire logic sel_tx_request_in,
  input wire logic sel_control_in,
  input wire logic sel_arb_in,
  input wire logic sel_fresh_data_in,
  input wire logic clear_pending_select_in,
  input wire logic ctl_tx_request_in,
  input wire logic ctl_fresh_data_in,
  input wire logic ctl_irq_pending_in,
  input wire logic arb_valid_in,
  input wire logic tx_hit_in, // transmitted successfully
  input wire logic tx_irq_enable_in,
  input wire logic rx_hit_in, // accepted frame stored
  input wire logic rx_remote_in,
  input wire logic rx_dir_tx_in,
  input wire logic remote_reply_enable_in,
  input wire logic mask_use_enable_in,
  input wire logic rx_irq_enable_in,
  input wire logic shift_hit_in, // contents copied to shift register
  output logic tx_req_out,
  output logic fresh_out,
  output logic pend_out,
  output logic valid_out
);

  // ---------------------------------------------------------------
  // clears first, then interface loads, then hardware sets,
  // so an event landing on a clear is never lost
  // ---------------------------------------------------------------
  always_comb begin
    logic live_rx;
    logic live_tx;
    logic rmt_set;
    logic rmt_data;
    live_rx = rx_hit_in && valid_in;
    live_tx = tx_hit_in && valid_in;
    rmt_set = rx_remote_in && rx_dir_tx_in && remote_reply_enable_in;
    rmt_data = rx_remote_in && rx_dir_tx_in && !remote_reply_enable_in &&
               mask_use_enable_in;
    tx_req_out = tx_req_in;
    fresh_out = fresh_in;
    pend_out = pend_in;
    valid_out = valid_in;
    // read-direction transfer clears
    if (xfer_hit_in && !xfer_write_in) begin
      if (sel_fresh_data_in) begin
        fresh_out = 1'b0;
      end
      if (clear_pending_select_in) begin
        pend_out = 1'b0;
      end
    end
    if (shift_hit_in) begin
      fresh_out = 1'b0;
    end
    if (live_tx) begin
      tx_req_out = 1'b0;
    end
    if (live_rx && rmt_data) begin
      tx_req_out = 1'b0;
    end
    // write-direction transfer loads
    if (xfer_hit_in && xfer_write_in) begin
      if (sel_control_in) begin
        fresh_out = ctl_fresh_data_in;
        pend_out = ctl_irq_pending_in;
        if (!sel_tx_request_in) begin
          tx_req_out = ctl_tx_request_in;
        end
      end
      if (sel_tx_request_in) begin
        tx_req_out = 1'b1;
      end
      if (sel_arb_in) begin
        valid_out = arb_valid_in;
      end
    end
    // hardware sets win last
    if (live_rx && rmt_set) begin
      tx_req_out = 1'b1;
    end
    if (live_rx && (!rx_remote_in || rmt_data)) begin
      fresh_out = 1'b1;
      if (rx_irq_enable_in) begin
        pend_out = 1'b1;
      end
    end
    if (live_tx && tx_irq_enable_in) begin
      pend_out = 1'b1;
    end
  end

endmodule : cms_object_flags
`default_nettype wire

// file: verification/cms_status_summary_chk.sv
// ---------------------------------------------------------------
// concurrent checks on the ports of the message status summary top
// ---------------------------------------------------------------
// assumes: one clock domain, synchronous active-low reset, bound below
`timescale 1ns/1ns
`default_nettype none
module cms_status_summary_chk
  import cms_pkg::*;
(
  input wire logic clk_in, rst_n_in, reg_select_in, reg_write_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic xfer_valid_in, xfer_write_in, sel_tx_request_in, sel_control_in,
  input wire logic sel_arb_in, clear_pending_select_in, arb_valid_in,
  input wire logic [5:0] xfer_obj_in, tx_obj_in, tx_candidate_obj_out,
  input wire logic tx_done_in, tx_irq_enable_in, rx_store_in, shift_load_in,
  input wire logic bus_valid_msg_in, init_in, higher_irq_in, tx_candidate_valid_out,
  input wire logic [15:0] interrupt_source_id_out,
  input wire logic irq_pending_any_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // no flag event at all this cycle, so the summary must hold still
  logic quiet;
  assign quiet = !xfer_valid_in && !tx_done_in && !rx_store_in && !shift_load_in
    && !bus_valid_msg_in && !init_in;
  // the candidate under a successful send, other traffic excluded
  logic sent;
  assign sent = tx_done_in && tx_candidate_valid_out && tx_obj_in == tx_candidate_obj_out
    && !xfer_valid_in && !rx_store_in;

  property p_reset; $rose(rst_n_in) |-> reg_rdata_out == CMS_RDATA_RST
    && !tx_candidate_valid_out && interrupt_source_id_out == CMS_ID_NONE; endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");
  property p_idle; !(reg_select_in && reg_write_n_in) |=> reg_rdata_out == CMS_RDATA_RST;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not zero when idle");
  property p_unmapped; reg_select_in && reg_write_n_in
    && !(reg_addr_in[7:2] inside {6'h20, 6'h24, 6'h28, 6'h2C}) |=> reg_rdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_quiet; quiet && $stable(higher_irq_in) && $past(rst_n_in) |=>
    $stable(tx_candidate_obj_out) && $stable(interrupt_source_id_out)
    && $stable(irq_pending_any_out) && $stable(tx_candidate_valid_out); endproperty
  a_quiet: assert property (p_quiet) else $error("status moved without an event");
  property p_higher; higher_irq_in |=> interrupt_source_id_out == CMS_ID_STATUS; endproperty
  a_higher: assert property (p_higher) else $error("higher source not reported");
  property p_id; interrupt_source_id_out != CMS_ID_STATUS |-> (irq_pending_any_out ?
    interrupt_source_id_out inside {[1:32]} : interrupt_source_id_out == CMS_ID_NONE);
  endproperty
  a_id: assert property (p_id) else $error("source id disagrees with pending");
  property p_cand; tx_candidate_valid_out ? tx_candidate_obj_out inside {[1:32]}
    : tx_candidate_obj_out == 6'h00; endproperty
  a_cand: assert property (p_cand) else $error("candidate number out of range");
  property p_sent; sent |=> tx_candidate_obj_out != $past(tx_obj_in); endproperty
  a_sent: assert property (p_sent) else $error("request kept after send");
  property p_txirq; sent && tx_irq_enable_in && !higher_irq_in |=> irq_pending_any_out
    && interrupt_source_id_out <= {10'h000, $past(tx_obj_in)}; endproperty
  a_txirq: assert property (p_txirq) else $error("no pending after send");
  property p_set; xfer_valid_in && xfer_write_in && sel_arb_in && arb_valid_in
    && sel_tx_request_in && !sel_control_in && xfer_obj_in inside {[1:31]}
    && !tx_candidate_valid_out && !tx_done_in && !rx_store_in && !shift_load_in
    |=> tx_candidate_valid_out && tx_candidate_obj_out == $past(xfer_obj_in); endproperty
  a_set: assert property (p_set) else $error("request not set by transfer");
  property p_cip; xfer_valid_in && !xfer_write_in && clear_pending_select_in
    && xfer_obj_in != 6'h00 && interrupt_source_id_out == {10'h000, xfer_obj_in}
    && !tx_done_in && !rx_store_in |=> interrupt_source_id_out != {10'h000, $past(xfer_obj_in)};
  endproperty
  a_cip: assert property (p_cip) else $error("pending not cleared by read");
endmodule : cms_status_summary_chk

bind cms_status_summary cms_status_summary_chk chk_u (.*);
`default_nettype wire

// file: verification/tb_cms_status_summary.sv
// ---------------------------------------------------------------
// self-checking bench for the message status summary
// ---------------------------------------------------------------
// assumes: checker bound onto the top, 20 MHz clock, no random stimulus
`timescale 1ns/1ns
`default_nettype none
module tb_cms_status_summary;
  import cms_pkg::*;
  logic clk_in, rst_n_in, reg_select_in, reg_write_n_in;
  logic [1:0] reg_size_in;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic xfer_valid_in, xfer_write_in, sel_tx_request_in, sel_control_in, sel_arb_in;
  logic sel_fresh_data_in, clear_pending_select_in, ctl_tx_request_in, ctl_fresh_data_in;
  logic ctl_irq_pending_in, arb_valid_in, tx_done_in, tx_irq_enable_in, rx_store_in;
  logic rx_remote_in, rx_dir_tx_in, remote_reply_enable_in, mask_use_enable_in;
  logic rx_irq_enable_in, shift_load_in, bus_valid_msg_in, init_in, higher_irq_in;
  logic tx_candidate_valid_out, irq_pending_any_out;
  logic [5:0] xfer_obj_in, tx_obj_in, rx_obj_in, shift_obj_in, tx_candidate_obj_out;
  logic [15:0] interrupt_source_id_out;
  int n_fail;
  int comparisons;
  // mask selects {tx request, control, arbitration, fresh data, clear pending}
  localparam logic [4:0] S_TX = 5'h10, S_CTL = 5'h08, S_ARB = 5'h04, S_FR = 5'h02;
  localparam logic [4:0] S_CIP = 5'h01;

  cms_status_summary dut_u (.*);

  // 50 ns period
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic final_report;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // read one word; data stands one cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    reg_select_in <= 1'b1;
    reg_write_n_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_select_in <= 1'b0;
    #1 cmp(reg_rdata_out, exp);
  endtask : rd

  // write all ones; must leave every flag alone
  task automatic wr(input logic [7:0] a);
    @(posedge clk_in);
    reg_select_in <= 1'b1;
    reg_write_n_in <= 1'b0;
    reg_addr_in <= a;
    reg_wdata_in <= 32'hFFFF_FFFF;
    @(posedge clk_in);
    reg_select_in <= 1'b0;
    reg_write_n_in <= 1'b1;
  endtask : wr

  // interface transfer; val = {ctl tx, ctl fresh, ctl pending, arb valid}
  task automatic xf(input logic w, input logic [5:0] o, input logic [4:0] s,
                    input logic [3:0] val);
    @(posedge clk_in);
    xfer_valid_in <= 1'b1;
    xfer_write_in <= w;
    xfer_obj_in <= o;
    {sel_tx_request_in, sel_control_in, sel_arb_in, sel_fresh_data_in,
     clear_pending_select_in} <= s;
    {ctl_tx_request_in, ctl_fresh_data_in, ctl_irq_pending_in, arb_valid_in} <= val;
    @(posedge clk_in);
    xfer_valid_in <= 1'b0;
  endtask : xf

  // cfg = {remote, dir transmit, reply enable, mask use, rx irq enable}
  task automatic rxs(input logic [5:0] o, input logic [4:0] cfg);
    @(posedge clk_in);
    rx_store_in <= 1'b1;
    rx_obj_in <= o;
    {rx_remote_in, rx_dir_tx_in, remote_reply_enable_in, mask_use_enable_in,
     rx_irq_enable_in} <= cfg;
    @(posedge clk_in);
    rx_store_in <= 1'b0;
  endtask : rxs

  task automatic txd(input logic [5:0] o, input logic ie);
    @(posedge clk_in);
    tx_done_in <= 1'b1;
    tx_obj_in <= o;
    tx_irq_enable_in <= ie;
    @(posedge clk_in);
    tx_done_in <= 1'b0;
  endtask : txd

  task automatic shl(input logic [5:0] o);
    @(posedge clk_in);
    shift_load_in <= 1'b1;
    shift_obj_in <= o;
    @(posedge clk_in);
    shift_load_in <= 1'b0;
  endtask : shl

  // status outputs as {cand valid, any pending, cand, source id}
  task automatic chk_out(input logic v, input logic p, input logic [5:0] o,
                         input logic [15:0] id);
    cmp({8'h00, tx_candidate_valid_out, irq_pending_any_out, tx_candidate_obj_out,
         interrupt_source_id_out}, {8'h00, v, p, o, id});
  endtask : chk_out

  task automatic t_reset;
    logic [7:0] ofs [8] = '{8'h80, 8'h82, 8'h90, 8'h92, 8'hA0, 8'hA2, 8'hB0, 8'hB2};
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    rd(8'hC0, 32'h0);
    wr(8'h80);
    wr(8'hB2);
    rd(8'h80, 32'h0);
    rd(8'hB0, 32'h0);
    chk_out(1'b0, 1'b0, 6'h00, 16'h0000);
  endtask : t_reset

  task automatic t_set;
    xf(1'b1, 6'h01, S_TX | S_ARB, 4'h1);
    xf(1'b1, 6'h11, S_ARB, 4'h1);
    xf(1'b1, 6'h20, S_ARB, 4'h1);
    xf(1'b1, 6'h11, S_TX, 4'h0);
    rd(8'hB0, 32'h8001_0001);
    rd(8'h80, 32'h0001_0001);
    rd(8'h82, 32'h0000_0001);
    chk_out(1'b1, 1'b0, 6'h01, 16'h0000);
  endtask : t_set

  task automatic t_txdone;
    txd(6'h01, 1'b1);
    rd(8'h80, 32'h0001_0000);
    rd(8'hA0, 32'h0000_0001);
    chk_out(1'b1, 1'b1, 6'h11, 16'h0001);
    @(posedge clk_in);
    higher_irq_in <= 1'b1;
    @(posedge clk_in);
    #1 chk_out(1'b1, 1'b1, 6'h11, 16'h8000);
    @(posedge clk_in);
    higher_irq_in <= 1'b0;
  endtask : t_txdone

  task automatic t_ctrl;
    xf(1'b1, 6'h11, S_CTL, 4'h6);
    rd(8'h80, 32'h0);
    rd(8'h90, 32'h0001_0000);
    rd(8'hA0, 32'h0001_0001);
    chk_out(1'b0, 1'b1, 6'h00, 16'h0001);
    xf(1'b0, 6'h11, S_FR | S_CIP, 4'h0);
    rd(8'h90, 32'h0);
    rd(8'hA0, 32'h0000_0001);
    xf(1'b0, 6'h01, S_CIP, 4'h0);
    rd(8'hA0, 32'h0);
    xf(1'b1, 6'h01, S_CTL, 4'h8);
    rd(8'h80, 32'h0000_0001);
    chk_out(1'b1, 1'b0, 6'h01, 16'h0000);
  endtask : t_ctrl

  task automatic t_rx;
    rxs(6'h01, 5'h01);
    rd(8'h90, 32'h0000_0001);
    rd(8'hA0, 32'h0000_0001);
    shl(6'h01);
    rd(8'h90, 32'h0);
    rxs(6'h05, 5'h01);
    rd(8'h90, 32'h0);
    rd(8'hA0, 32'h0000_0001);
  endtask : t_rx

  task automatic t_remote;
    rxs(6'h20, 5'h1C);
    rd(8'h82, 32'h0000_8000);
    rxs(6'h20, 5'h1A);
    rd(8'h80, 32'h0000_0001);
    rd(8'h90, 32'h8000_0000);
    xf(1'b1, 6'h20, S_ARB, 4'h0);
    rd(8'hB0, 32'h0001_0001);
    xf(1'b1, 6'h20, S_TX | S_ARB, 4'h1);
    xf(1'b1, 6'h20, S_CTL, 4'h0);
    xf(1'b1, 6'h20, S_TX, 4'h0);
    txd(6'h01, 1'b0);
    #1 chk_out(1'b0, 1'b1, 6'h00, 16'h0001);
    @(posedge clk_in);
    init_in <= 1'b1;
    @(posedge clk_in);
    init_in <= 1'b0;
    #1 chk_out(1'b1, 1'b1, 6'h20, 16'h0001);
  endtask : t_remote

  // watchdog: run needs well under 1000 cycles
  initial begin
    #200000;
    n_fail++;
    final_report;
  end

  initial begin
    n_fail = 0;
    comparisons = 0;
    rst_n_in = 1'b0;
    reg_write_n_in = 1'b1;
    {reg_select_in, reg_size_in, reg_addr_in, reg_wdata_in, xfer_valid_in, xfer_write_in,
     xfer_obj_in, sel_tx_request_in, sel_control_in, sel_arb_in, sel_fresh_data_in,
     clear_pending_select_in, ctl_tx_request_in, ctl_fresh_data_in, ctl_irq_pending_in,
     arb_valid_in, tx_done_in, tx_obj_in, tx_irq_enable_in, rx_store_in, rx_obj_in,
     rx_remote_in, rx_dir_tx_in, remote_reply_enable_in, mask_use_enable_in,
     rx_irq_enable_in, shift_load_in, shift_obj_in, bus_valid_msg_in, init_in,
     higher_irq_in} = '0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_set;
    t_txdone;
    t_ctrl;
    t_rx;
    t_remote;
    final_report;
  end
endmodule : tb_cms_status_summary
`default_nettype wire
